// *** hdl/isa_glue.sv ***
`timescale 1ns/1ps
`include "isa_glue_defs.svh"

// Summary of operation
// - Bus A20 pin is driven except while a slot master owns the bus.
// - Bus A20 is CPU A20 gated by the gate pin or port 92 bit 1; it is DMA A20 in hold cycles outside master mode.
// - CPU A20 mask output is low when gate pin and port 92 bit 1 are low.
// - Address buffer direction is high in master mode, low otherwise.
// - AEN is high in DMA cycles, one clock late, except while a slot master owns the bus.
// - BALE stays high in master, refresh and DMA cycles.
// - Byte enables mark high and low lanes; inputs in master mode, outputs otherwise.
// - Buffer enable is low during slot cycles, or always when the option is set.
// - Address lines are inputs in CPU and master cycles, outputs in other hold cycles.
// - I/O commands are driven for CPU and DMA cycles, sampled in master cycles.
// - Memory commands are active for every slot memory access below 16MB; inputs in master mode.
// - Low-memory commands only for memory accesses below 1MB.
// - Keyboard controller select on I/O accesses to 060h or 064h.
// - RTC address strobe on I/O writes to 070h.
// - RTC read strobe on reads of 071h, write strobe on writes to 071h.
// - ROM select is memory read qualified by the ROM range decode.
// - Slot data buffer directions are high for writes toward the slot bus.
// - NMI on local parity error, or on enabled channel check.
// - CPU reset output is high while the reset request input is low.
// - A master asserting its flag at acknowledge gets the bus, synchronised here.
module isa_glue
  import isa_glue_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire cpu_req_t cpu_req,
  input wire logic ads_n,
  input wire logic hlda,
  input wire logic locack_n,
  input wire logic local_mem_hit,
  input wire logic [15:0] cpu_data_in,
  input wire logic cpu_addr_bit20_in,
  input wire logic addr20_gate_in,
  input wire logic a20_i,
  output logic a20_o,
  output logic a20_oe,
  output logic addr20_mask_n,
  output logic addr_buf_dir_n,
  input wire logic dma_cycle,
  input wire logic refresh_active,
  input wire logic [23:1] dma_addr,
  input wire logic [1:0] dma_be_n,
  input wire cmd_n_t dma_cmd,
  input wire logic dack_active,
  input wire logic master_n,
  output logic aen,
  output logic bale,
  input wire logic [1:0] be_i,
  output logic [1:0] be_o,
  output logic be_oe,
  input wire logic [23:1] addr_i,
  output logic [23:1] addr_o,
  output logic addr_oe,
  input wire cmd_n_t cmd_i,
  output cmd_n_t cmd_o,
  output logic cmd_oe,
  output logic smemr_n,
  output logic smemw_n,
  input wire logic buf_always_en,
  output logic level_shift_buf_en_n,
  input wire logic iochrdy,
  input wire logic iocs16_n,
  input wire logic memcs16_n,
  input wire logic zero_ws_n,
  output logic kbd_ctrl_sel_n,
  output logic rtc_addr_strobe,
  output logic rtc_read_n,
  output logic rtc_write_n,
  output logic rom_sel_n,
  output logic slot_data_hi_dir,
  output logic slot_data_lo_dir,
  input wire logic parity_err,
  input wire logic iochck_n,
  input wire logic iochck_nmi_en,
  output logic nmi,
  input wire logic cpu_reset_req_n,
  output logic cpu_reset_out,
  output logic isa_done
);

  localparam logic [`CNT_W-1:0] CMD_CYC = `CNT_W'((`ISA_CMD_NS * `CLK_MHZ + 999) / 1000);
  localparam logic [`CNT_W-1:0] ZWS_CYC = `CNT_W'((`ZWS_CMD_NS * `CLK_MHZ + 999) / 1000);

  function automatic logic io_hit(input logic [23:1] a, input logic [1:0] be_n, input logic [15:0] p);
    logic lane;
    lane = p[0] ? !be_n[1] : !be_n[0];
    io_hit = (a[`IO_DEC_MSB:1] == p[`IO_DEC_MSB:1]) && lane;
  endfunction : io_hit

  function automatic logic rom_hit(input logic [23:1] a);
    logic [23:0] b;
    b = {a, 1'b0};
    rom_hit = (b >= `ROM_LO_BASE && b <= `ROM_LO_TOP) || (b >= `ROM_HI_BASE);
  endfunction : rom_hit

  pin_in_t pin_raw;
  pin_in_t pin_s;

  // Every slot-side pin crosses two flops before use; this is the glue
  // between the free-running slot master and the local clock.
  assign pin_raw = '{master_n: master_n, gate: addr20_gate_in, iochck_n: iochck_n,
                     rst_req_n: cpu_reset_req_n, iochrdy: iochrdy, iocs16_n: iocs16_n,
                     memcs16_n: memcs16_n, zero_ws_n: zero_ws_n, a20: a20_i,
                     be_n: be_i, cmd: cmd_i, addr: addr_i};

  sync_bits #(.W($bits(pin_in_t))) u_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .d(pin_raw),
    .q(pin_s)
  );

  cyc_state_t state_ff;
  cpu_req_t req_ff;
  logic [15:0] wdata_ff;
  logic [`CNT_W-1:0] cnt_ff;
  logic hi_phase_ff;
  logic cs16_ff;
  logic master_ff;
  logic alt_gate_ff;
  logic done_ff;
  logic cmd_end;
  logic need_split;

  // Master mode.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      master_ff <= 1'b0;
    end else if (!master_ff && dack_active && !pin_s.master_n) begin
      master_ff <= 1'b1;
    end else if (master_ff && !dack_active) begin
      master_ff <= 1'b0;
    end
  end

  // CPU cycle sequencer for slot accesses.
  assign cmd_end = (state_ff == ST_CMD) &&
                   (((cnt_ff >= CMD_CYC - `CNT_W'(1)) && pin_s.iochrdy) ||
                    ((cnt_ff >= ZWS_CYC - `CNT_W'(1)) && !pin_s.zero_ws_n));
  assign need_split = (req_ff.be_n == 2'b00) && !cs16_ff && !hi_phase_ff;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_ff <= ST_IDLE;
      hi_phase_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          hi_phase_ff <= 1'b0;
          if (!ads_n && !hlda && locack_n && !local_mem_hit) begin
            state_ff <= ST_LEAD;
          end
        end
        ST_LEAD: begin
          state_ff <= ST_CMD;
        end
        ST_CMD: begin
          if (cmd_end && need_split) begin
            hi_phase_ff <= 1'b1;
            state_ff <= ST_GAP;
          end else if (cmd_end) begin
            done_ff <= 1'b1;
            state_ff <= ST_IDLE;
          end
        end
        ST_GAP: begin
          state_ff <= ST_LEAD;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      req_ff <= '0;
      wdata_ff <= '0;
    end else if (state_ff == ST_IDLE && !ads_n) begin
      req_ff <= cpu_req;
      wdata_ff <= cpu_data_in;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cnt_ff <= '0;
    end else if (state_ff == ST_CMD) begin
      cnt_ff <= cnt_ff + `CNT_W'(1);
    end else begin
      cnt_ff <= '0;
    end
  end

  // A word cycle that no slave claims as 16-bit is rerun on the high lane.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cs16_ff <= 1'b0;
    end else if (state_ff == ST_LEAD && !hi_phase_ff) begin
      cs16_ff <= 1'b0;
    end else if (state_ff == ST_CMD) begin
      cs16_ff <= cs16_ff | (req_ff.mio ? !pin_s.memcs16_n : !pin_s.iocs16_n);
    end
  end

  // Alternate gate bit, written by a CPU I/O write to port 092h.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      alt_gate_ff <= 1'b0;
    end else if (state_ff == ST_LEAD && !hi_phase_ff && !req_ff.mio && req_ff.wr &&
                 io_hit(req_ff.addr, req_ff.be_n, `IO_A20_ALT)) begin
      alt_gate_ff <= wdata_ff[`A20_ALT_BIT];
    end
  end

  // Source selection for decodes: master pins, DMA, or the CPU cycle.
  logic cpu_a20;
  logic [1:0] cpu_be_n;
  logic [23:1] src_addr;
  logic [1:0] src_be_n;
  logic cpu_slot;
  cmd_n_t cpu_cmd;
  cmd_n_t src_cmd;

  assign cpu_a20 = cpu_addr_bit20_in & (pin_s.gate | alt_gate_ff);
  assign cpu_be_n = hi_phase_ff ? 2'b01 : req_ff.be_n;
  assign cpu_slot = (state_ff == ST_CMD);

  always_comb begin
    cpu_cmd = '{ior_n: 1'b1, iow_n: 1'b1, memr_n: 1'b1, memw_n: 1'b1};
    if (cpu_slot) begin
      cpu_cmd.ior_n = !(!req_ff.mio && !req_ff.wr);
      cpu_cmd.iow_n = !(!req_ff.mio && req_ff.wr);
      // A 24-bit address is always below 16MB, so every memory access qualifies.
      cpu_cmd.memr_n = !(req_ff.mio && !req_ff.wr);
      cpu_cmd.memw_n = !(req_ff.mio && req_ff.wr);
    end
  end

  always_comb begin
    if (master_ff) begin
      src_addr = pin_s.addr;
      src_addr[20] = pin_s.a20;
      src_be_n = pin_s.be_n;
      src_cmd = pin_s.cmd;
    end else if (dma_cycle) begin
      src_addr = dma_addr;
      src_be_n = dma_be_n;
      src_cmd = dma_cmd;
    end else begin
      src_addr = req_ff.addr;
      src_addr[20] = cpu_a20;
      src_be_n = cpu_be_n;
      src_cmd = cpu_cmd;
    end
  end

  // Pin directions and the address path.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      a20_o <= 1'b0;
      a20_oe <= 1'b0;
      addr20_mask_n <= 1'b0;
      addr_buf_dir_n <= 1'b0;
      addr_o <= '0;
      addr_oe <= 1'b0;
      be_o <= 2'b11;
      be_oe <= 1'b0;
    end else begin
      a20_oe <= !master_ff;
      a20_o <= (hlda && !master_ff) ? dma_addr[20] : cpu_a20;
      addr20_mask_n <= pin_s.gate | alt_gate_ff;
      addr_buf_dir_n <= master_ff;
      addr_oe <= hlda && !master_ff;
      addr_o <= {dma_addr[23:21], 1'b0, dma_addr[19:1]};
      be_oe <= !master_ff;
      be_o <= dma_cycle ? dma_be_n : cpu_be_n;
    end
  end

  // Slot commands and control strobes.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cmd_o <= '{ior_n: 1'b1, iow_n: 1'b1, memr_n: 1'b1, memw_n: 1'b1};
      cmd_oe <= 1'b0;
      aen <= 1'b0;
      bale <= 1'b0;
      level_shift_buf_en_n <= 1'b1;
      smemr_n <= 1'b1;
      smemw_n <= 1'b1;
    end else begin
      cmd_oe <= !master_ff;
      cmd_o <= dma_cycle ? dma_cmd : cpu_cmd;
      aen <= dma_cycle && !master_ff;
      bale <= master_ff || refresh_active || dma_cycle || (state_ff == ST_LEAD);
      level_shift_buf_en_n <= !(buf_always_en || (state_ff != ST_IDLE) || master_ff ||
                                dma_cycle || refresh_active);
      smemr_n <= !(!src_cmd.memr_n && ({src_addr, 1'b0} < `SMEM_LIMIT));
      smemw_n <= !(!src_cmd.memw_n && ({src_addr, 1'b0} < `SMEM_LIMIT));
    end
  end

  // Fixed peripheral decodes.
  logic io_rd;
  logic io_wr;
  logic io_any;

  assign io_rd = !src_cmd.ior_n;
  assign io_wr = !src_cmd.iow_n;
  assign io_any = io_rd || io_wr;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      kbd_ctrl_sel_n <= 1'b1;
      rtc_addr_strobe <= 1'b0;
      rtc_read_n <= 1'b1;
      rtc_write_n <= 1'b1;
      rom_sel_n <= 1'b1;
    end else begin
      kbd_ctrl_sel_n <= !(io_any && (io_hit(src_addr, src_be_n, `IO_KBD_DATA) ||
                                     io_hit(src_addr, src_be_n, `IO_KBD_STAT)));
      rtc_addr_strobe <= io_wr && io_hit(src_addr, src_be_n, `IO_RTC_ADDR);
      rtc_read_n <= !(io_rd && io_hit(src_addr, src_be_n, `IO_RTC_DATA));
      rtc_write_n <= !(io_wr && io_hit(src_addr, src_be_n, `IO_RTC_DATA));
      rom_sel_n <= !(!src_cmd.memr_n && rom_hit(src_addr));
    end
  end

  // Data buffer direction, NMI and CPU reset.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      slot_data_hi_dir <= 1'b0;
      slot_data_lo_dir <= 1'b0;
    end else begin
      slot_data_hi_dir <= (state_ff != ST_IDLE) && req_ff.wr && !cpu_be_n[1];
      slot_data_lo_dir <= (state_ff != ST_IDLE) && req_ff.wr && !cpu_be_n[0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      nmi <= 1'b0;
    end else begin
      nmi <= parity_err || (iochck_nmi_en && !pin_s.iochck_n);
    end
  end

  // The CPU is held in reset while the system reset itself is active.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cpu_reset_out <= 1'b1;
    end else begin
      cpu_reset_out <= !pin_s.rst_req_n;
    end
  end

  assign isa_done = done_ff;

endmodule : isa_glue

// *** hdl/isa_glue_defs.svh ***
`ifndef ISA_GLUE_DEFS_SVH
`define ISA_GLUE_DEFS_SVH

// Clock rate in MHz and the command timings in ns.
`define CLK_MHZ 20
`define ISA_CMD_NS 375
`define ZWS_CMD_NS 100
`define CNT_W 4

// Fixed I/O decodes; only address bits 9:1 take part, as on the slot bus.
`define IO_DEC_MSB 9
`define IO_A20_ALT 16'h0092
`define A20_ALT_BIT 1
`define IO_KBD_DATA 16'h0060
`define IO_KBD_STAT 16'h0064
`define IO_RTC_ADDR 16'h0070
`define IO_RTC_DATA 16'h0071

// Memory ranges.
`define SMEM_LIMIT 24'h100000
`define ROM_LO_BASE 24'h0E0000
`define ROM_LO_TOP 24'h0FFFFF
`define ROM_HI_BASE 24'hFE0000

`endif

// *** hdl/isa_glue_pkg.sv ***
package isa_glue_pkg;

  // Slot bus commands, active low as on the pins.
  typedef struct packed {
    logic ior_n;
    logic iow_n;
    logic memr_n;
    logic memw_n;
  } cmd_n_t;

  // Cycle request latched from the CPU local bus.
  typedef struct packed {
    logic [23:1] addr;
    logic [1:0] be_n;
    logic mio;
    logic wr;
    logic dc;
  } cpu_req_t;

  // Pins from the slot side that pass the synchroniser.
  typedef struct packed {
    logic master_n;
    logic gate;
    logic iochck_n;
    logic rst_req_n;
    logic iochrdy;
    logic iocs16_n;
    logic memcs16_n;
    logic zero_ws_n;
    logic a20;
    logic [1:0] be_n;
    cmd_n_t cmd;
    logic [23:1] addr;
  } pin_in_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_LEAD = 4'b0010,
    ST_CMD = 4'b0100,
    ST_GAP = 4'b1000
  } cyc_state_t;

endpackage : isa_glue_pkg

// *** hdl/sync_bits.sv ***
`timescale 1ns/1ps

// Two-stage synchroniser for a bundle of asynchronous levels.
module sync_bits #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      meta_ff <= '0;
      q_ff <= '0;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end

  assign q = q_ff;

endmodule : sync_bits

// *** dv/slot_resp.sv ***
`timescale 1ns/1ps
module slot_resp
  import isa_glue_pkg::*;
(
  input wire logic clk_sys,
  input wire cmd_n_t cmd_o,
  input wire logic [2:0] mode,
  output logic iochrdy,
  output logic iocs16_n,
  output logic memcs16_n,
  output logic zero_ws_n
);
  logic active;
  logic [2:0] hold_ff;
  assign active = cmd_o != 4'hF;
  // Width selects come from the slave's address decode, so they stand for the whole cycle.
  assign iocs16_n = !mode[0];
  assign memcs16_n = !mode[0];
  // Released lines float high through the board pull-ups.
  assign zero_ws_n = !(mode[1] && active);
  assign iochrdy = !(mode[2] && active && hold_ff != 3'h0);
  always_ff @(posedge clk_sys) begin
    if (!active) begin
      hold_ff <= 3'h4;
    end else if (hold_ff != 3'h0) begin
      hold_ff <= hold_ff - 3'h1;
    end
  end
endmodule : slot_resp

// *** dv/isa_glue_chk.sv ***
`timescale 1ns/1ps
module isa_glue_chk
  import isa_glue_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic cpu_reset_req_n,
  input wire logic cpu_reset_out,
  input wire logic parity_err,
  input wire logic nmi,
  input wire logic dma_cycle,
  input wire logic refresh_active,
  input wire logic aen,
  input wire logic bale,
  input wire logic buf_always_en,
  input wire logic level_shift_buf_en_n,
  input wire logic a20_oe,
  input wire logic addr_buf_dir_n,
  input wire logic be_oe,
  input wire logic cmd_oe,
  input wire logic isa_done,
  input wire logic dack_active,
  input wire cmd_n_t cmd_o
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  property p_rst;
    !cpu_reset_req_n [*4] |=> cpu_reset_out;
  endproperty
  a_rst: assert property (p_rst) else $error("cpu reset missing");
  property p_par;
    parity_err |=> nmi;
  endproperty
  a_par: assert property (p_par) else $error("nmi missing");
  property p_aen;
    dma_cycle |=> aen;
  endproperty
  a_aen: assert property (p_aen) else $error("aen low in dma");
  property p_bale;
    dma_cycle || refresh_active |=> bale;
  endproperty
  a_bale: assert property (p_bale) else $error("bale low");
  property p_buf;
    buf_always_en |=> !level_shift_buf_en_n;
  endproperty
  a_buf: assert property (p_buf) else $error("buffer off");
  // Both pins leave reset low, so the pairing only holds from the second edge after release.
  property p_dir;
    !$past(srst) |-> a20_oe == !addr_buf_dir_n;
  endproperty
  a_dir: assert property (p_dir) else $error("a20 vs dir");
  property p_mst;
    !dack_active |-> ##2 !addr_buf_dir_n;
  endproperty
  a_mst: assert property (p_mst) else $error("master dir held");
  property p_oe;
    be_oe == cmd_oe && be_oe == a20_oe;
  endproperty
  a_oe: assert property (p_oe) else $error("enables differ");
  property p_done;
    isa_done |=> !isa_done && cmd_o == 4'hF;
  endproperty
  a_done: assert property (p_done) else $error("done end");
endmodule : isa_glue_chk

bind isa_glue isa_glue_chk u_chk (.*);

// *** dv/tb.sv ***
`timescale 1ns/1ps
module tb;
  import isa_glue_pkg::*;
  logic clk_sys = 1'h0, srst = 1'h1, ads_n = 1'h1, hlda = 1'h0, locack_n = 1'h1, local_mem_hit = 1'h0;
  logic cpu_addr_bit20_in = 1'h0, addr20_gate_in = 1'h0, dma_cycle = 1'h0, refresh_active = 1'h0;
  logic dack_active = 1'h0, master_n = 1'h1, buf_always_en = 1'h0, parity_err = 1'h0, iochck_n = 1'h1;
  logic iochck_nmi_en = 1'h0, cpu_reset_req_n = 1'h1, m_a20 = 1'h0, io, wr;
  logic a20_i, a20_o, a20_oe, addr20_mask_n, addr_buf_dir_n, aen, bale, be_oe, addr_oe, cmd_oe;
  logic smemr_n, smemw_n, level_shift_buf_en_n, iochrdy, iocs16_n, memcs16_n, zero_ws_n;
  logic kbd_ctrl_sel_n, rtc_addr_strobe, rtc_read_n, rtc_write_n, rom_sel_n, nmi, cpu_reset_out;
  logic slot_data_hi_dir, slot_data_lo_dir, isa_done;
  logic [1:0] dma_be_n = 2'h2, m_be = 2'h2, be_i, be_o, be;
  logic [2:0] mode = 3'h0;
  logic [15:0] cpu_data_in = 16'h0;
  logic [23:1] dma_addr = 23'h100, m_addr = 23'h0, addr_i, addr_o, a;
  logic [31:0] r;
  cpu_req_t cpu_req = '0;
  cmd_n_t dma_cmd = 4'hF, m_cmd = 4'hF, cmd_i, cmd_o;
  int bad_count = 0, n_checks = 0, seed = 3273, i;
  // A slot master drives the shared lines only while the design has let go of them.
  assign cmd_i = cmd_oe ? cmd_o : m_cmd;
  assign addr_i = addr_oe ? addr_o : m_addr;
  assign be_i = be_oe ? be_o : m_be;
  assign a20_i = a20_oe ? a20_o : m_a20;
  isa_glue dut (.*);
  slot_resp resp (.*);
  always #25 clk_sys = !clk_sys;
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int k);
    repeat (k) @(posedge clk_sys);
    #2;
  endtask : step
  function automatic logic [13:0] expv(input logic io, input logic wr, input logic [23:1] a,
    input logic [1:0] be);
    logic [23:0] b;
    logic lo, hi, p38;
    b = {a, 1'h0};
    lo = io && !be[0];
    hi = io && !be[1];
    p38 = a[9:1] == 9'h038;
    return {1'h1, io && !wr, io && wr, !io && !wr, !io && wr,
      lo && (a[9:1] == 9'h030 || a[9:1] == 9'h032), lo && wr && p38, hi && !wr && p38, hi && wr && p38,
      !io && !wr && (b >= 24'h0E0000 && b <= 24'h0FFFFF || b >= 24'hFE0000),
      !io && !wr && b < 24'h100000, !io && wr && b < 24'h100000, wr, 1'h1};
  endfunction : expv
  // Collects every strobe seen during one CPU slot cycle, so the check does not hang on exact timing.
  task automatic cyc(input logic io, input logic wr, input logic [23:1] a, input logic [1:0] be);
    logic [13:0] g;
    int n;
    g = '0;
    n = 0;
    cpu_req = '{a, be, !io, wr, 1'h1};
    cpu_addr_bit20_in = a[20];
    ads_n = 1'h0;
    step(1);
    ads_n = 1'h1;
    while (n < 60) begin
      step(1);
      g = g | {isa_done, !cmd_o.ior_n, !cmd_o.iow_n, !cmd_o.memr_n, !cmd_o.memw_n, !kbd_ctrl_sel_n,
        rtc_addr_strobe, !rtc_read_n, !rtc_write_n, !rom_sel_n, !smemr_n, !smemw_n,
        slot_data_hi_dir | slot_data_lo_dir, !level_shift_buf_en_n};
      n = (isa_done === 1'h1) ? 57 : n + 1;
    end
    chk(g, expv(io, wr, a, be));
  endtask : cyc
  initial begin
    step(12);
    srst = 1'h0;
    cpu_addr_bit20_in = 1'h1;
    step(5);
    chk({a20_o, addr20_mask_n}, 2'h0);
    addr20_gate_in = 1'h1;
    step(5);
    chk({a20_o, addr20_mask_n}, 2'h3);
    addr20_gate_in = 1'h0;
    for (i = 0; i < 2; i++) begin
      cpu_data_in = {14'h0, !i[0], 1'h0};
      cyc(1'h1, 1'h1, 23'h49, 2'h2);
      cpu_addr_bit20_in = 1'h1;
      step(5);
      chk({a20_o, addr20_mask_n}, {2{!i[0]}});
    end
    addr20_gate_in = 1'h1;
    $display("test a20 done");
    cpu_reset_req_n = 1'h0;
    step(5);
    chk(cpu_reset_out, 1'h1);
    cpu_reset_req_n = 1'h1;
    step(5);
    chk(cpu_reset_out, 1'h0);
    parity_err = 1'h1;
    step(2);
    chk(nmi, 1'h1);
    parity_err = 1'h0;
    iochck_n = 1'h0;
    step(5);
    chk(nmi, 1'h0);
    iochck_nmi_en = 1'h1;
    step(5);
    chk(nmi, 1'h1);
    iochck_n = 1'h1;
    buf_always_en = 1'h1;
    step(5);
    chk({nmi, level_shift_buf_en_n}, 2'h0);
    buf_always_en = 1'h0;
    $display("test reset nmi done");
    hlda = 1'h1;
    dma_cycle = 1'h1;
    dma_cmd.memr_n = 1'h0;
    step(3);
    chk({aen, bale, smemr_n, addr_oe}, 4'hD);
    chk({be_o, addr_o[14:1]}, 16'h8100);
    dma_cycle = 1'h0;
    dma_cmd = 4'hF;
    refresh_active = 1'h1;
    step(2);
    chk(bale, 1'h1);
    refresh_active = 1'h0;
    dack_active = 1'h1;
    master_n = 1'h0;
    step(6);
    chk({addr_buf_dir_n, a20_oe, be_oe, cmd_oe, addr_oe}, 5'h10);
    m_addr = 23'h32;
    m_cmd.ior_n = 1'h0;
    step(5);
    chk(kbd_ctrl_sel_n, 1'h0);
    m_cmd = 4'hF;
    dack_active = 1'h0;
    master_n = 1'h1;
    step(6);
    chk({addr_buf_dir_n, a20_oe, be_oe, cmd_oe, addr_oe}, 5'h0F);
    hlda = 1'h0;
    // A cycle that local memory claims must never reach the slot bus.
    local_mem_hit = 1'h1;
    ads_n = 1'h0;
    step(1);
    ads_n = 1'h1;
    local_mem_hit = 1'h0;
    step(2);
    chk({cmd_o, level_shift_buf_en_n}, 5'h1F);
    $display("test dma master done");
    for (i = 0; i < 30; i++) begin
      r = $random(seed);
      mode = r[12:10];
      cpu_data_in = r[15:0];
      case (i)
        0, 1: a = 23'h30;
        2, 3: a = 23'h32;
        4, 5, 6, 7: a = 23'h38;
        8: a = 23'h7F000;
        9: a = 23'h40000;
        10: a = 23'h7F0000;
        default: a = r[31:9];
      endcase
      io = i < 8 || (i > 10 && r[0]);
      wr = (i < 11) ? i[0] : r[1];
      be = (i == 4 || i == 5) ? 2'h1 : ((i < 8) ? 2'h2 : 2'h0);
      if (i > 10) be = io ? {r[2], !r[2]} : {r[3], r[2] && !r[3]};
      cyc(io, wr, a, be);
    end
    $display("test cycles done");
    results();
  end
  initial begin
    #1000000;
    bad_count++;
    results();
  end
endmodule : tb
